// ---- rtl/sarcv_core.sv ----
// modules: select, read/convert control, busy, tri-state result bus and result fifo
// =====================================================
// Notes on behaviour
// - both lines low 40ns starts conversion
// - busy low from start until result stored
// - two's complement result, msb on bit 11
// - requests ignored while busy is low
// - hold sample when start qualifies
// - select and read/convert or'd, level triggered
// - select may be tied low permanently
// - bus driven only when read, selected, idle
// - busy rising edge marks valid data
// - select falling with convert low starts
// - read/convert falling with select low starts
// - select falling with read high drives
// - requested read during conversion drives later
// - both low, idle: result kept, bus off
// - select high keeps bus off
// - code range 800 to 7ff, midscale 000
module sarcv_core #(
  parameter int unsigned CONV_CYC = sarcv_pkg::CONV_CYC_DEF,
  parameter int unsigned DEPTH = sarcv_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sel_b, // active low select pin
  input wire logic rd_conv, // read high, convert low
  input wire logic [11:0] sample_code, // digitised input from the analog side
  output logic hold, // sample/hold in hold state
  output logic busy_b, // low while converting
  output logic [11:0] parallel_result_bus_o, // bus drive value
  output logic [11:0] parallel_result_bus_oe, // bus drive enables
  output logic res_valid, // result stream out
  input wire logic res_ready,
  output logic [11:0] res_data
);
  // =====================================================
  // pin synchronisers
  logic sel_m_q; // first stage, read only by second
  logic sel_s_q; // synced select
  logic rc_m_q;
  logic rc_s_q; // synced read/convert
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_m_q <= 1'b1;
      sel_s_q <= 1'b1;
      rc_m_q <= 1'b1;
      rc_s_q <= 1'b1;
    end else begin
      sel_m_q <= sel_b;
      sel_s_q <= sel_m_q;
      rc_m_q <= rd_conv;
      rc_s_q <= rc_m_q;
    end
  end

  // =====================================================
  // start qualification
  localparam int unsigned LW = 8; // low-time counter width
  localparam logic [LW-1:0] LOW_MAX = LW'(sarcv_pkg::START_LOW_CYC);
  logic req_lvl; // or of active-low lines, level based
  logic [LW-1:0] low_q; // cycles both lines low
  logic armed_q; // a fresh low period may start once
  logic start;
  // both low combines as or of the lines, low meaning asserted
  assign req_lvl = !(sel_s_q || rc_s_q);
  // start when low long enough, armed and idle
  assign start = req_lvl && (low_q >= LOW_MAX - 1'b1) && armed_q && busy_b;

  // low-time counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_q <= '0;
    end else if (!req_lvl) begin
      low_q <= '0;
    end else if (low_q != LOW_MAX) begin
      low_q <= low_q + 1'b1;
    end
  end

  // arming: one start per low period, either edge finishes it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_q <= 1'b1;
    end else if (!req_lvl) begin
      armed_q <= 1'b1;
    end else if (start || !busy_b) begin
      armed_q <= 1'b0;
    end
  end

  // =====================================================
  // conversion timer and busy
  localparam int unsigned CW = $clog2(CONV_CYC + 1);
  logic [CW-1:0] conv_q; // remaining cycles
  logic done;
  assign done = !busy_b && (conv_q == CW'(1));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_b <= 1'b1;
      conv_q <= '0;
      hold <= 1'b0;
    end else if (start) begin
      busy_b <= 1'b0;
      hold <= 1'b1;
      conv_q <= CW'(CONV_CYC);
    end else if (done) begin
      busy_b <= 1'b1;
      hold <= 1'b0;
      conv_q <= '0;
    end else if (!busy_b) begin
      conv_q <= conv_q - 1'b1;
    end
  end

  // =====================================================
  // captured sample and output register
  logic [11:0] samp_q; // held code
  logic [11:0] result_q; // output register
  logic push_rdy;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      samp_q <= sarcv_pkg::RESULT_RST;
    end else if (start) begin
      samp_q <= sample_code; // two's complement, bit 11 is msb
    end
  end
  // result updated in the same edge busy rises
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result_q <= sarcv_pkg::RESULT_RST;
    end else if (done) begin
      result_q <= samp_q;
    end
  end

  // result stream; a full fifo refuses and drops the newest result
  sarcv_fifo #(
    .WIDTH(12),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(done),
    .in_ready(push_rdy),
    .in_data(samp_q),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

  // =====================================================
  // bus drive: read high, selected, idle
  logic drive;
  assign drive = rc_s_q && !sel_s_q && busy_b;
  assign parallel_result_bus_o = result_q;
  assign parallel_result_bus_oe = {12{drive}};

  // =====================================================
  // assertions
  logic busy_d1_q; // busy one edge ago
  logic [CW:0] low_run_q; // edges busy seen low, one spare bit
  // delayed busy for the one-start check
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_d1_q <= 1'b1;
    end else begin
      busy_d1_q <= busy_b;
    end
  end
  // length of the running busy-low period, saturating so it never wraps
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_run_q <= '0;
    end else if (busy_b) begin
      low_run_q <= '0; // idle, period over
    end else if (low_run_q != '1) begin
      low_run_q <= low_run_q + 1'b1;
    end
  end

  // start qualification checks
  // a start needs the qualified low time
  AST_START_NEEDS_LOW: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(busy_b) |-> $past(req_lvl) && $past(low_q) >= LOW_MAX - 1'b1)
    else $error("conversion started without qualified low time");

  // busy falls only through a qualified start
  AST_FALL_FROM_START: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(busy_b) |-> $past(start))
    else $error("busy fell without a start");

  // a high on either line restarts the low count
  AST_LOW_RESTARTS: assert property (@(posedge clk) disable iff (!rst_b)
    !req_lvl |=> low_q == '0)
    else $error("low count kept across a high line");

  // a released request arms the next start
  AST_REARM: assert property (@(posedge clk) disable iff (!rst_b)
    !req_lvl |=> armed_q)
    else $error("start not re-armed after the lines rose");

  // one low period gives one conversion
  AST_ONE_START: assert property (@(posedge clk) disable iff (!rst_b)
    (busy_b && !busy_d1_q && req_lvl) |-> !start)
    else $error("second conversion from a single low period");

  // busy and timing checks
  // a start enters hold and drops busy at once
  AST_START_HOLDS: assert property (@(posedge clk) disable iff (!rst_b)
    start |=> !busy_b && hold)
    else $error("start did not drop busy and enter hold");

  // busy stays low well past its fall
  AST_BUSY_LENGTH: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(busy_b) |-> !busy_b [*8])
    else $error("busy too short");

  // busy low for exactly the configured count
  AST_BUSY_EXACT: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(busy_b) |-> low_run_q == (CW+1)'(CONV_CYC))
    else $error("busy low time differs from the conversion count");

  // requests during a conversion never reload the timer
  AST_NO_START_BUSY: assert property (@(posedge clk) disable iff (!rst_b)
    (!busy_b && !done) |=> !busy_b && conv_q == $past(conv_q) - 1'b1)
    else $error("conversion timer disturbed while busy");

  // completion releases busy and hold together
  AST_DONE_RELEASES: assert property (@(posedge clk) disable iff (!rst_b)
    done |=> busy_b && !hold)
    else $error("busy or hold not released at completion");

  // hold tracks busy
  AST_HOLD_WITH_BUSY: assert property (@(posedge clk) disable iff (!rst_b)
    hold == !busy_b)
    else $error("hold and busy disagree");

  // result path checks
  // new result stands as busy rises
  AST_RESULT_AT_RISE: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(busy_b) |-> result_q == $past(samp_q))
    else $error("result not updated when busy rises");

  // output register moves only on completion
  AST_RESULT_HELD: assert property (@(posedge clk) disable iff (!rst_b)
    !done |=> result_q == $past(result_q))
    else $error("output register changed outside completion");

  // captured code stays put while converting
  AST_SAMPLE_STABLE: assert property (@(posedge clk) disable iff (!rst_b)
    !busy_b |=> $stable(samp_q))
    else $error("held code changed during conversion");

  // every stored result enters the stream when there is room
  AST_FIFO_GETS_RESULT: assert property (@(posedge clk) disable iff (!rst_b)
    (done && push_rdy) |=> res_valid)
    else $error("completed result missing from the stream");

  // bus drive checks
  // deselected means no drive
  AST_OFF_SELECT_HIGH: assert property (@(posedge clk) disable iff (!rst_b)
    sel_s_q |-> parallel_result_bus_oe == 12'h000)
    else $error("bus driven while deselected");

  // converting or convert mode means no drive
  AST_OFF_CONVERTING: assert property (@(posedge clk) disable iff (!rst_b)
    (!busy_b || !rc_s_q) |-> parallel_result_bus_oe == 12'h000)
    else $error("bus driven during conversion or convert mode");

  // read, selected and idle drives every line
  AST_DRIVE_WHEN_READ: assert property (@(posedge clk) disable iff (!rst_b)
    (rc_s_q && !sel_s_q && busy_b) |-> parallel_result_bus_oe == 12'hfff)
    else $error("bus not driven in read mode");

  // a read pending through a conversion drives on completion
  AST_AUTO_DRIVE: assert property (@(posedge clk) disable iff (!rst_b)
    ($rose(busy_b) && rc_s_q && !sel_s_q) |-> parallel_result_bus_oe == 12'hfff)
    else $error("bus not driven after conversion completes");
endmodule

// =====================================================
// module: small synchronous fifo carrying conversion results
module sarcv_fifo #(
  parameter int unsigned WIDTH = 12, // word width
  parameter int unsigned DEPTH = 32 // entries held
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // =====================================================
  // storage and pointers
  localparam int unsigned AW = $clog2(DEPTH); // pointer width
  logic [WIDTH-1:0] mem [DEPTH]; // storage array
  logic [AW-1:0] wr_q; // write pointer
  logic [AW-1:0] rd_q; // read pointer
  logic [AW:0] cnt_q; // fill level, one bit wider than pointers
  logic push; // word taken this cycle
  logic pop; // word handed on this cycle
  // level flags; full only at exactly depth words
  assign in_ready = (cnt_q != (AW+1)'(DEPTH)); // honest full
  assign out_valid = (cnt_q != '0); // honest empty
  // oldest word always on the output
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage write, no reset needed on the array
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // pointers wrap at depth, level follows push and pop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1; // fill only
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1; // drain only
      end
    end
  end
endmodule

// ---- rtl/sarcv_pkg.sv ----
// package: timing, widths and code constants for the converter control port
package sarcv_pkg;
  // =====================================================
  // widths and codes
  localparam int unsigned DATA_W = 12; // result width
  localparam logic [11:0] CODE_POS_FS = 12'h7ff; // positive full scale
  localparam logic [11:0] CODE_MID = 12'h000; // midscale
  localparam logic [11:0] CODE_MID_M1 = 12'hfff; // one step below midscale
  localparam logic [11:0] CODE_NEG_FS = 12'h800; // negative full scale
  localparam logic [11:0] RESULT_RST = 12'h000; // result register reset value
  localparam int unsigned STEP_UV = 4880; // step size in microvolts
  // =====================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10; // 100 mhz clock
  localparam int unsigned START_LOW_NS = 40; // least low time of a start
  // least time rounds up, at least one cycle
  localparam int unsigned START_LOW_CYC =
    (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYC_DEF = 100; // cycles per conversion
  localparam int unsigned FIFO_DEPTH = 32; // result fifo depth
endpackage

// ---- rtl/sarcv_fifo.sv ----
// no logic here: the result fifo module sits in the core design file

// ---- dv/sarcv_host.sv ----
// host side model: resolves the data pins and latches them on the edge after busy rises
module sarcv_host (
  input wire logic clk,
  input wire logic busy_b,
  input wire logic [11:0] bus_o,
  input wire logic [11:0] bus_oe,
  output logic [11:0] latched
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] bus_w; // level seen on the pins
  logic [11:0] park_q = 12'ha5a; // floating pattern, never a stale value
  logic busy_q = 1'b1; // busy one edge ago
  // undriven bits wander each idle cycle, still while converting
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      bus_w[i] = bus_oe[i] ? bus_o[i] : park_q[i];
    end
  end
  // latch on the edge after busy rises, once the pins have settled
  always @(posedge clk) begin
    if (busy_b) begin
      park_q <= ~park_q;
    end
    busy_q <= busy_b;
    if (busy_b && !busy_q) begin
      latched <= bus_w;
    end
  end
endmodule

// ---- dv/sar_adc_convert_read_port_tb.sv ----
// testbench: conversions, bus enables and result fifo
module sar_adc_convert_read_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CONV = 20; // short conversion
  logic clk, rst_b, sel_b, rd_conv, res_ready, hold, busy_b, res_valid;
  logic [11:0] sample_code, bus_o, bus_oe, res_data, latched;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [11:0] exp_q[$]; // codes in conversion order
  sarcv_core #(.CONV_CYC(CONV), .DEPTH(sarcv_pkg::FIFO_DEPTH)) i_dut (.clk(clk),
    .rst_b(rst_b), .sel_b(sel_b), .rd_conv(rd_conv), .sample_code(sample_code),
    .hold(hold), .busy_b(busy_b), .parallel_result_bus_o(bus_o),
    .parallel_result_bus_oe(bus_oe), .res_valid(res_valid), .res_ready(res_ready),
    .res_data(res_data));
  sarcv_host i_host (.clk(clk), .busy_b(busy_b), .bus_o(bus_o), .bus_oe(bus_oe),
    .latched(latched));
  // =====================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  // =====================================================
  // shared tasks
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy_b !== lvl && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk({11'h0, busy_b}, {11'h0, lvl});
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // =====================================================
  // scenarios
  // one conversion, started by select or by read/convert
  task automatic conv(input logic [11:0] code, input logic via_sel);
    @(negedge clk);
    sample_code = code;
    if (via_sel) begin
      sel_b = 1'b1;
      rd_conv = 1'b0;
      repeat (4) @(negedge clk);
      chk(bus_oe, 12'h000);
      sel_b = 1'b0;
    end else begin
      rd_conv = 1'b0;
      repeat (4) @(negedge clk);
      chk(bus_oe, 12'h000);
    end
    chk({11'h0, busy_b}, 12'h001);
    wait_busy(1'b0);
    chk({11'h0, hold}, 12'h001);
    chk(bus_oe, 12'h000);
    rd_conv = 1'b1;
    repeat (2) @(negedge clk);
    rd_conv = 1'b0;
    repeat (5) @(negedge clk);
    rd_conv = 1'b1;
    repeat (3) @(negedge clk);
    chk(bus_oe, 12'h000);
    wait_busy(1'b1);
    chk(bus_o, code);
    repeat (3) @(negedge clk);
    chk(bus_oe, 12'hfff);
    chk(latched, code);
    repeat (100) @(negedge clk);
    chk({11'h0, busy_b}, 12'h001);
    exp_q.push_back(code);
  endtask
  // read enabled by a falling select with read/convert high
  task automatic rd_sel();
    @(negedge clk);
    sel_b = 1'b1;
    repeat (4) @(negedge clk);
    chk(bus_oe, 12'h000);
    sel_b = 1'b0;
    repeat (4) @(negedge clk);
    chk(bus_oe, 12'hfff);
    chk(bus_o, exp_q[$]);
  endtask
  // drain the stalled fifo: 32 kept, the overflow entry dropped
  task automatic drain();
    int n;
    n = 0;
    @(negedge clk);
    res_ready = 1'b1;
    repeat (40) begin
      if (res_valid === 1'b1) begin
        if (n < 32) begin
          chk(res_data, exp_q[n]);
        end
        n++;
      end
      @(negedge clk);
    end
    chk(12'(n), 12'h020);
    chk({11'h0, res_valid}, 12'h000);
  endtask
  // =====================================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    sel_b = 1'b0;
    rd_conv = 1'b1;
    sample_code = 12'h000;
    res_ready = 1'b0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk(bus_o, sarcv_pkg::RESULT_RST);
    chk(bus_oe, 12'h000);
    repeat (2) @(negedge clk);
    chk(bus_oe, 12'hfff);
    conv(sarcv_pkg::CODE_POS_FS, 1'b0);
    conv(sarcv_pkg::CODE_MID, 1'b1);
    conv(sarcv_pkg::CODE_MID_M1, 1'b0);
    conv(sarcv_pkg::CODE_NEG_FS, 1'b1);
    rd_sel();
    for (int i = 0; i < 29; i++) begin
      conv(12'(i * 37 + 5), 1'(i));
    end
    drain();
    summarize();
  end
endmodule
